/* hw/run_freq_command_select.sv */
// Run/stop, direction and frequency reference source selector
// Assumes all inputs synchronous except terminals, which are synced here
`timescale 1ns/10ps
module run_freq_command_select
   import cmd_sel_pkg::*;
#(
   parameter int unsigned ALARM_CYC = `DUAL_ALARM_CYC,
   parameter int unsigned CLOSE_CYC = `MIN_CLOSE_CYC
)(
   input  wire logic                  clk_i,
   input  wire logic                  rst_b_i,
   input  wire logic [`TERM_N-1:0]    term_i,
   input  wire logic [5:0]            term_func_i [`TERM_N],
   input  wire logic [2:0]            main_run_src_i,
   input  wire logic [2:0]            alt_run_src_i,
   input  wire logic                  dir_lock_i,
   input  wire logic                  key_run_i,
   input  wire logic                  key_rev_i,
   input  wire logic                  comm_run_i,
   input  wire logic                  comm_rev_i,
   input  wire logic                  logic_run_i,
   input  wire logic                  logic_rev_i,
   input  wire logic                  sched_run_i,
   input  wire logic                  sched_rev_i,
   input  wire logic [2:0]            main_freq_src_i,
   input  wire logic [2:0]            alt_freq_src_i,
   input  wire logic                  freq_combine_i,
   input  wire logic [7:0]            analog_mode_i,
   input  wire logic                  ain2_current_i,
   input  wire logic [`FREQ_W-1:0]    keypad_freq_i,
   input  wire logic [`FREQ_W-1:0]    stage0_freq_i,
   input  wire logic [`FREQ_W-1:0]    ain1_freq_i,
   input  wire logic [`FREQ_W-1:0]    ain2_volt_freq_i,
   input  wire logic [`FREQ_W-1:0]    ain2_curr_freq_i,
   input  wire logic [`FREQ_W-1:0]    comm_freq_i,
   input  wire logic                  comm_freq_wr_i,
   input  wire logic                  comm_mem_en_i,
   input  wire logic                  power_down_i,
   input  wire logic [`FREQ_W-1:0]    sched_freq_i,
   input  wire logic [`FREQ_W-1:0]    max_freq_i,
   input  wire logic [`FREQ_W-1:0]    min_freq_i,
   input  wire logic                  min_detect_i,
   output logic                       run_o,
   output logic                       reverse_o,
   output logic                       alt_run_active_o,
   output logic [1:0]                 wire_mode_o,
   output logic [`FREQ_W-1:0]         freq_ref_o,
   output logic                       dual_direction_alarm_o,
   output logic                       same_source_error_o,
   output logic                       wire_mode_conflict_error_o,
   output logic                       below_min_freq_warning_o
);
   term_if tif ();
   term_cond #(.MIN_CYC(CLOSE_CYC)) u_cond (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .term_i  (term_i),
      .tif     (tif)
   );

   // Function decode over all terminals, three-wire only from the third terminal on
   logic fn_run_sw, fn_ain_sw, fn_up, fn_dn, fn_three, fn_latch;
   logic up_assigned, dn_assigned, dir_in, latch_en;
   always_comb begin
      fn_run_sw   = 1'b0;
      fn_ain_sw   = 1'b0;
      fn_up       = 1'b0;
      fn_dn       = 1'b0;
      fn_three    = 1'b0;
      fn_latch    = 1'b0;
      up_assigned = 1'b0;
      dn_assigned = 1'b0;
      dir_in      = 1'b0;
      for (int i = 0; i < `TERM_N; i++) begin
         if (term_func_i[i] == `FN_RUN_SWITCH && tif.level[i])
            fn_run_sw = 1'b1;
         if (term_func_i[i] == `FN_ANALOG_SWITCH && tif.level[i])
            fn_ain_sw = 1'b1;
         if (term_func_i[i] == `FN_UP) begin
            up_assigned = 1'b1;
            fn_up       = fn_up | tif.level[i];
         end
         if (term_func_i[i] == `FN_DOWN) begin
            dn_assigned = 1'b1;
            fn_dn       = fn_dn | tif.level[i];
         end
         if (i >= 2 && term_func_i[i] == `FN_THREE_WIRE)
            fn_three = 1'b1;
         if (term_func_i[i] == `FN_LATCH_WIRE)
            fn_latch = 1'b1;
      end
      // Fifth terminal carries direction in three-wire mode
      dir_in   = tif.level[4];
      latch_en = fn_latch & ~fn_three;
   end
   assign wire_mode_conflict_error_o = fn_latch & fn_three;

   wire_mode_e mode;
   always_comb begin
      if (latch_en)
         mode = WIRE_LATCH;
      else if (fn_three)
         mode = WIRE_THREE;
      else
         mode = WIRE_TWO;
   end
   assign wire_mode_o = mode;

   // Terminal run state machine
   logic        t_run_ff, t_rev_ff, nxt_t_run, nxt_t_rev;
   logic [31:0] both_cnt_ff, nxt_both_cnt;
   logic        alarm_ff, nxt_alarm;
   logic        two_wire_cfg, t1, t2;
   assign two_wire_cfg = (term_func_i[0] == `FN_FWD_RUN)
                       && (term_func_i[1] == `FN_REV_RUN);
   assign t1 = tif.level[0];
   assign t2 = tif.level[1];
   always_comb begin
      nxt_t_run    = t_run_ff;
      nxt_t_rev    = t_rev_ff;
      nxt_both_cnt = '0;
      nxt_alarm    = 1'b0;
      unique case (mode)
         WIRE_TWO: begin
            nxt_t_run = 1'b0;
            nxt_t_rev = 1'b0;
            if (two_wire_cfg) begin
               if (t1 && t2) begin
                  // Conflicting commands stop, alarm only if sustained
                  if (both_cnt_ff < ALARM_CYC)
                     nxt_both_cnt = both_cnt_ff + 32'h1;
                  else
                     nxt_both_cnt = both_cnt_ff;
                  nxt_alarm = (nxt_both_cnt >= ALARM_CYC);
               end else if (t1) begin
                  nxt_t_run = 1'b1;
               end else if (t2 && !dir_lock_i) begin
                  nxt_t_run = 1'b1;
                  nxt_t_rev = 1'b1;
               end
            end
         end
         WIRE_THREE: begin
            // Stop is a normally closed contact: open means stop
            if (!t2)
               nxt_t_run = 1'b0;
            else if (tif.held[0])
               nxt_t_run = 1'b1;
            nxt_t_rev = dir_in & ~dir_lock_i;
         end
         WIRE_LATCH: begin
            if (tif.held[4])
               nxt_t_run = 1'b0;
            else if (tif.held[0]) begin
               nxt_t_run = 1'b1;
               nxt_t_rev = 1'b0;
            end else if (tif.held[1] && !dir_lock_i) begin
               nxt_t_run = 1'b1;
               nxt_t_rev = 1'b1;
            end
         end
         default: begin
            nxt_t_run = 1'b0;
            nxt_t_rev = 1'b0;
         end
      endcase
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         t_run_ff    <= 1'b0;
         t_rev_ff    <= 1'b0;
         both_cnt_ff <= '0;
         alarm_ff    <= 1'b0;
      end else begin
         t_run_ff    <= nxt_t_run;
         t_rev_ff    <= nxt_t_rev;
         both_cnt_ff <= nxt_both_cnt;
         alarm_ff    <= nxt_alarm;
      end
   end
   assign dual_direction_alarm_o = alarm_ff;

   // Run source selection
   run_src_e run_src;
   logic     run_nxt, rev_nxt;
   assign alt_run_active_o = fn_run_sw;
   always_comb begin
      run_src = run_src_e'(fn_run_sw ? alt_run_src_i : main_run_src_i);
      run_nxt = 1'b0;
      rev_nxt = 1'b0;
      unique case (run_src)
         RUN_KEYPAD: begin
            run_nxt = key_run_i;
            rev_nxt = key_rev_i & ~dir_lock_i;
         end
         RUN_TERMINAL: begin
            run_nxt = t_run_ff;
            rev_nxt = t_rev_ff;
         end
         RUN_COMM: begin
            run_nxt = comm_run_i;
            rev_nxt = comm_rev_i & ~dir_lock_i;
         end
         RUN_LOGIC: begin
            run_nxt = logic_run_i;
            rev_nxt = logic_rev_i & ~dir_lock_i;
         end
         RUN_SCHED: begin
            run_nxt = sched_run_i;
            rev_nxt = sched_rev_i & ~dir_lock_i;
         end
         default: begin
            run_nxt = 1'b0;
            rev_nxt = 1'b0;
         end
      endcase
   end

   // Up/down ramp and communication frequency store
   freq_t       ud_ff, nxt_ud, comm_ff, nxt_comm;
   logic [19:0] ud_div_ff, nxt_ud_div;
   always_comb begin
      nxt_ud_div = (ud_div_ff == `UPDOWN_DIV) ? 20'h0 : ud_div_ff + 20'h1;
      nxt_ud     = ud_ff;
      if (up_assigned && dn_assigned && ud_div_ff == `UPDOWN_DIV) begin
         if (fn_up && !fn_dn && ud_ff < max_freq_i)
            nxt_ud = ud_ff + `UPDOWN_STEP;
         else if (fn_dn && !fn_up && ud_ff != '0)
            nxt_ud = ud_ff - `UPDOWN_STEP;
      end
      nxt_comm = comm_ff;
      if (comm_freq_wr_i)
         nxt_comm = comm_freq_i;
      else if (power_down_i && !comm_mem_en_i)
         nxt_comm = '0;
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ud_ff     <= '0;
         ud_div_ff <= '0;
         comm_ff   <= '0;
      end else begin
         ud_ff     <= nxt_ud;
         ud_div_ff <= nxt_ud_div;
         comm_ff   <= nxt_comm;
      end
   end

   // Analog references
   freq_t ain2_f, ain1_path;
   logic [`FREQ_W:0] ain_sum;
   always_comb begin
      ain2_f  = ain2_current_i ? ain2_curr_freq_i : ain2_volt_freq_i;
      ain_sum = {1'b0, ain1_freq_i} + {1'b0, ain2_f};
      if (analog_mode_i == `ANALOG_MODE_SUM)
         ain1_path = ain_sum[`FREQ_W] ? max_freq_i
                                      : ain_sum[`FREQ_W-1:0];
      else if (analog_mode_i == `ANALOG_MODE_AUX && fn_ain_sw)
         ain1_path = ain2_f;
      else
         ain1_path = ain1_freq_i;
   end

   function automatic freq_t pick(input logic [2:0] sel, input logic alt);
      freq_t f;
      f = '0;
      unique case (freq_src_e'(sel))
         FRQ_KEYPAD: f = alt ? stage0_freq_i : keypad_freq_i;
         FRQ_AIN1:   f = ain1_path;
         FRQ_UPDOWN: f = ud_ff;
         FRQ_COMM:   f = comm_ff;
         FRQ_RSV4:   f = '0;
         FRQ_RSV5:   f = '0;
         FRQ_SCHED:  f = sched_freq_i;
         FRQ_AIN2:   f = (analog_mode_i == `ANALOG_MODE_AUX) ?
                         ain2_f : '0;
         default:    f = '0;
      endcase
      return f;
   endfunction

   freq_t            main_f, alt_f, ref_f, out_f;
   logic [`FREQ_W:0] comb_sum;
   logic             below;
   always_comb begin
      main_f   = pick(main_freq_src_i, 1'b0);
      alt_f    = pick(alt_freq_src_i, 1'b1);
      comb_sum = {1'b0, main_f} + {1'b0, alt_f};
      if (freq_combine_i)
         ref_f = comb_sum[`FREQ_W] ? max_freq_i
                                   : comb_sum[`FREQ_W-1:0];
      else
         ref_f = main_f;
      below = ref_f < min_freq_i;
      out_f = (below && min_detect_i) ? min_freq_i : ref_f;
   end
   assign same_source_error_o = freq_combine_i
                   && (main_freq_src_i == alt_freq_src_i);

   logic  run_ff, rev_ff, warn_ff;
   freq_t freq_ff;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run_ff  <= 1'b0;
         rev_ff  <= 1'b0;
         warn_ff <= 1'b0;
         freq_ff <= '0;
      end else begin
         run_ff  <= run_nxt;
         rev_ff  <= rev_nxt;
         warn_ff <= below & ~min_detect_i;
         freq_ff <= out_f;
      end
   end
   assign run_o                    = run_ff;
   assign reverse_o                = rev_ff;
   assign freq_ref_o               = freq_ff;
   assign below_min_freq_warning_o = warn_ff;
endmodule

/* hw/cmd_sel_consts.svh */
// Constants for the run and frequency command selector
// Assumes a 100 MHz clock; included by the package only, the modules take it from there
`ifndef CMD_SEL_CONSTS_SVH
`define CMD_SEL_CONSTS_SVH
`define CLK_MHZ          100
`define DUAL_ALARM_MS    500
`define DUAL_ALARM_CYC   (`DUAL_ALARM_MS * 1000 * `CLK_MHZ)
`define MIN_CLOSE_MS     50
`define MIN_CLOSE_CYC    (`MIN_CLOSE_MS * 1000 * `CLK_MHZ)
`define FN_FWD_RUN       6'h00
`define FN_REV_RUN       6'h01
`define FN_RUN_SWITCH    6'h0c
`define FN_ANALOG_SWITCH 6'h0d
`define FN_UP            6'h10
`define FN_DOWN          6'h11
`define FN_THREE_WIRE    6'h1a
`define FN_LATCH_WIRE    6'h35
`define FN_DIR_SELECT    6'h1b
`define ANALOG_MODE_AUX  8'h00
`define ANALOG_MODE_SUM  8'h0a
`define FREQ_W           16
`define UPDOWN_STEP      16'h0001
`define UPDOWN_DIV       20'h186a0
`define TERM_N           6
`endif

/* hw/cmd_sel_pkg.sv */
// Types shared by the run and frequency command selector
// Assumes cmd_sel_consts.svh is on the include path
`include "cmd_sel_consts.svh"
package cmd_sel_pkg;
   typedef enum logic [2:0] {
      RUN_KEYPAD, RUN_TERMINAL, RUN_COMM, RUN_LOGIC, RUN_SCHED
   } run_src_e;
   typedef enum logic [2:0] {
      FRQ_KEYPAD, FRQ_AIN1, FRQ_UPDOWN, FRQ_COMM,
      FRQ_RSV4, FRQ_RSV5, FRQ_SCHED, FRQ_AIN2
   } freq_src_e;
   typedef enum logic [1:0] {WIRE_TWO, WIRE_THREE, WIRE_LATCH} wire_mode_e;
   typedef logic [`FREQ_W-1:0] freq_t;
endpackage

/* hw/term_if.sv */
// Bundle of synchronised terminal levels and held flags passed from the conditioner
// Assumes one clock domain shared by both ends
`timescale 1ns/10ps
interface term_if;
   logic [`TERM_N-1:0] level;
   logic [`TERM_N-1:0] held;
   modport source (output level, output held);
   modport sink   (input level, input held);
endinterface

/* hw/term_cond.sv */
// Terminal conditioner: sync and closure-length measurement per input
// Assumes terminals are slow switch levels
`timescale 1ns/10ps
module term_cond
   import cmd_sel_pkg::*;
#(
   parameter int unsigned MIN_CYC = `MIN_CLOSE_CYC
)(
   input  wire logic                clk_i,
   input  wire logic                rst_b_i,
   input  wire logic [`TERM_N-1:0]  term_i,
   term_if.source                   tif
);
   genvar g;
   generate
      for (g = 0; g < `TERM_N; g++) begin : g_term
         logic        s1_ff, s2_ff, nxt_s1, nxt_s2;
         logic [23:0] cnt_ff, nxt_cnt;
         always_comb begin
            nxt_s1  = term_i[g];
            nxt_s2  = s1_ff;
            nxt_cnt = cnt_ff;
            if (!s2_ff)
               nxt_cnt = '0;
            else if (cnt_ff < 24'(MIN_CYC))
               nxt_cnt = cnt_ff + 24'h000001;
         end
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               s1_ff  <= 1'b0;
               s2_ff  <= 1'b0;
               cnt_ff <= '0;
            end else begin
               s1_ff  <= nxt_s1;
               s2_ff  <= nxt_s2;
               cnt_ff <= nxt_cnt;
            end
         end
         assign tif.level[g] = s2_ff;
         // Closure counted as held only after the minimum time
         assign tif.held[g]  = (cnt_ff >= 24'(MIN_CYC));
      end
   endgenerate
endmodule

/* verification/run_freq_monitor.sv */
// Checker for the run and frequency command selector
// Bound onto the top module; sees its ports only
`timescale 1ns/10ps
module run_freq_monitor
   import cmd_sel_pkg::*;
#(
   parameter int unsigned ALARM_CYC = 20
)(
   input wire logic        clk_i,
   input wire logic        rst_b_i,
   input wire logic [5:0]  term_i,
   input wire logic [5:0]  term_func_i [6],
   input wire logic        dir_lock_i,
   input wire logic [2:0]  main_freq_src_i,
   input wire logic [2:0]  alt_freq_src_i,
   input wire logic        freq_combine_i,
   input wire logic        min_detect_i,
   input wire logic [15:0] min_freq_i,
   input wire logic        run_o,
   input wire logic        reverse_o,
   input wire logic        alt_run_active_o,
   input wire logic [1:0]  wire_mode_o,
   input wire logic [15:0] freq_ref_o,
   input wire logic        dual_direction_alarm_o,
   input wire logic        same_source_error_o,
   input wire logic        wire_mode_conflict_error_o
);
   logic       has26, has53, sw12, both;
   logic [7:0] both_ff, nxt_both;
   always_comb begin
      has26 = 1'b0;
      has53 = 1'b0;
      sw12  = 1'b0;
      for (int k = 0; k < 6; k++) begin
         has26 |= (k > 1) && (term_func_i[k] == 6'h1a);
         has53 |= term_func_i[k] == 6'h35;
         sw12  |= (term_func_i[k] == 6'h0c) && term_i[k];
      end
      both = (term_i[1:0] == 2'b11) && (wire_mode_o == 2'h0);
      nxt_both = !both ? 8'h00 : both_ff + {7'h00, both_ff != 8'hff};
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) both_ff <= 8'h00;
      else both_ff <= nxt_both;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_both_held; both [*5]; endsequence
   sequence s_both_open; !both [*5]; endsequence
   a_same_src_err:
      assert property (same_source_error_o == (freq_combine_i
         && main_freq_src_i == alt_freq_src_i)) else $error("same src flag");
   a_mode_conflict:
      assert property (wire_mode_conflict_error_o == (has26 && has53))
      else $error("conflict flag wrong");
   a_wire_mode_sel:
      assert property (wire_mode_o == (has26 ? 2'h1 : (has53 ? 2'h2 : 2'h0)))
      else $error("wire mode wrong");
   a_rev_lock_hold:
      assert property (dir_lock_i [*4] |-> !(run_o && reverse_o))
      else $error("reverse while locked");
   a_both_stop:
      assert property (s_both_held |-> !run_o) else $error("runs on both");
   a_alarm_early:
      assert property (both_ff >= 8'd8 && both_ff < ALARM_CYC
         |-> !dual_direction_alarm_o) else $error("alarm too early");
   a_alarm_late:
      assert property (both_ff >= ALARM_CYC + 8 |-> dual_direction_alarm_o)
      else $error("alarm missing");
   a_alarm_clear:
      assert property (s_both_open |-> !dual_direction_alarm_o)
      else $error("alarm stuck");
   a_alt_switch:
      assert property (sw12 [*3] |-> alt_run_active_o)
      else $error("alt source not taken");
   a_rsv_zero:
      assert property (!freq_combine_i && !min_detect_i
         && main_freq_src_i inside {3'h4, 3'h5} |=> freq_ref_o == 16'h0000)
      else $error("reserved source not zero");
   a_min_clamp:
      assert property (min_detect_i [*2] ##0 $stable(min_freq_i)
         |-> freq_ref_o >= min_freq_i) else $error("below minimum");
endmodule

bind run_freq_command_select run_freq_monitor #(.ALARM_CYC(ALARM_CYC))
   run_freq_monitor_inst (.*);

/* verification/switch_bank.sv */
// Model of the external run, stop and selector switches
// Assumes press requests change on the falling clock edge
`timescale 1ns/10ps
module switch_bank #(
   parameter int unsigned MIN_CYC = 9
)(
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic [5:0] press_i,
   output logic      [5:0] term_o
);
   logic [7:0] held_ff [6];
   // Short taps are stretched, so no closure is ever too brief
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      for (int k = 0; k < 6; k++) begin
         if (!rst_b_i) begin
            term_o[k]  <= 1'b0;
            held_ff[k] <= 8'h00;
         end else begin
            term_o[k]  <= press_i[k]
                          | (term_o[k] & (held_ff[k] < MIN_CYC));
            held_ff[k] <= term_o[k] ? held_ff[k] + 8'h01 : 8'h00;
         end
      end
   end
endmodule

/* verification/run_freq_command_select_bench.sv */
// Self-checking bench for the run and frequency command selector
// Assumes the switch model and bound checker are compiled before it
`timescale 1ns/10ps
module run_freq_command_select_bench
   import cmd_sel_pkg::*;
;
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
   err_count++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
   localparam int unsigned ALARM = 20;
   logic clk_i, rst_b_i, dir_lock_i, key_run_i, key_rev_i, comm_run_i;
   logic comm_rev_i, logic_run_i, logic_rev_i, sched_run_i, sched_rev_i;
   logic freq_combine_i, ain2_current_i, comm_freq_wr_i, comm_mem_en_i;
   logic power_down_i, min_detect_i, run_o, reverse_o, alt_run_active_o;
   logic dual_direction_alarm_o, same_source_error_o;
   logic below_min_freq_warning_o, wire_mode_conflict_error_o;
   logic [5:0] term_i, press;
   logic [5:0] term_func_i [6];
   logic [2:0] main_run_src_i, alt_run_src_i, main_freq_src_i, alt_freq_src_i;
   logic [1:0] wire_mode_o;
   logic [7:0] analog_mode_i;
   freq_t keypad_freq_i, stage0_freq_i, ain1_freq_i, ain2_volt_freq_i;
   freq_t ain2_curr_freq_i, comm_freq_i, sched_freq_i, max_freq_i;
   freq_t min_freq_i, freq_ref_o;
   int err_count, n_compared;
   run_freq_command_select #(.ALARM_CYC(ALARM), .CLOSE_CYC(5))
      run_freq_command_select_inst (.*);
   switch_bank #(.MIN_CYC(9)) switch_bank_inst (.clk_i, .rst_b_i,
      .press_i(press), .term_o(term_i));
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic set_funcs(input logic [5:0] f2, input logic [5:0] f3);
      press = 6'h00;
      cyc(12);
      term_func_i = '{6'h00, 6'h01, f2, f3, 6'h02, 6'h02};
      cyc(2);
   endtask
   task automatic s_two_wire;
      set_funcs(6'h02, 6'h02);
      press = 6'h01; cyc(8);
      `CHK("fwd run", 2'b10, {run_o, reverse_o})
      press = 6'h02; cyc(12);
      `CHK("rev run", 2'b11, {run_o, reverse_o})
      dir_lock_i = 1'b1; cyc(6);
      `CHK("rev locked", 1'b0, run_o)
      dir_lock_i = 1'b0;
      press = 6'h03; cyc(ALARM);
      `CHK("both stop", 2'b00, {run_o, dual_direction_alarm_o})
      cyc(12);
      `CHK("dual alarm", 1'b1, dual_direction_alarm_o)
      press = 6'h00; cyc(14);
      `CHK("open stop", 2'b00, {run_o, dual_direction_alarm_o})
   endtask
   task automatic s_three_wire;
      set_funcs(6'h1a, 6'h02);
      `CHK("three mode", 2'h1, wire_mode_o)
      press = 6'h02; cyc(6);
      press = 6'h03; cyc(1);
      press = 6'h02; cyc(20);
      `CHK("three run", 2'b10, {run_o, reverse_o})
      // Fifth terminal closed with stop still closed selects reverse
      press = 6'h12; cyc(6);
      `CHK("three rev", 2'b11, {run_o, reverse_o})
      press = 6'h00; cyc(20);
      `CHK("three stop", 1'b0, run_o)
   endtask
   task automatic tap(input logic [5:0] p);
      press = p; cyc(1);
      press = 6'h00; cyc(20);
   endtask
   task automatic s_latch;
      set_funcs(6'h02, 6'h35);
      `CHK("latch mode", 2'h2, wire_mode_o)
      tap(6'h01);
      `CHK("latch fwd", 2'b10, {run_o, reverse_o})
      tap(6'h10);
      `CHK("latch stop", 1'b0, run_o)
      tap(6'h02);
      `CHK("latch rev", 2'b11, {run_o, reverse_o})
      term_func_i[2] = 6'h1a; cyc(2);
      `CHK("clash", 1'b1, wire_mode_conflict_error_o)
      `CHK("clash mode", 2'h1, wire_mode_o)
   endtask
   task automatic s_alt_run;
      logic [1:0] ex [5];
      ex = '{2'b11, 2'b00, 2'b10, 2'b11, 2'b10};
      set_funcs(6'h0c, 6'h02);
      {key_run_i, comm_run_i, logic_run_i, sched_run_i} = 4'hf;
      {key_rev_i, comm_rev_i, logic_rev_i, sched_rev_i} = 4'ha;
      press = 6'h04; cyc(6);
      `CHK("alt active", 1'b1, alt_run_active_o)
      for (int s = 0; s < 5; s++) begin
         alt_run_src_i = s[2:0]; cyc(6);
         `CHK("alt run", ex[s], {run_o, run_o & reverse_o})
      end
      press = 6'h00; cyc(16);
      `CHK("main again", 2'b00, {alt_run_active_o, run_o})
   endtask
   task automatic s_freq_src;
      freq_t ex [8];
      ex = '{16'h0111, 16'h0333, 16'h0000, 16'h0666,
             16'h0000, 16'h0000, 16'h0777, 16'h0444};
      comm_freq_wr_i = 1'b1; cyc(1);
      comm_freq_wr_i = 1'b0;
      for (int s = 0; s < 8; s++) begin
         main_freq_src_i = s[2:0]; cyc(3);
         // Up/down is unassigned here, so its store must still be zero
         `CHK("freq src", ex[s], freq_ref_o)
      end
      ain2_current_i = 1'b1; cyc(3);
      `CHK("ain2 current", 16'h0555, freq_ref_o)
      analog_mode_i = 8'h0a; cyc(3);
      `CHK("ain2 off aux", 16'h0000, freq_ref_o)
      main_freq_src_i = 3'h1; cyc(3);
      `CHK("analog sum", 16'h0888, freq_ref_o)
   endtask
   task automatic s_combine;
      set_funcs(6'h0d, 6'h02);
      analog_mode_i = 8'h00; ain2_current_i = 1'b0;
      press = 6'h04; cyc(6);
      `CHK("ain switch", 16'h0444, freq_ref_o)
      press = 6'h00; cyc(14);
      freq_combine_i = 1'b1; cyc(3);
      `CHK("main plus alt", 16'h0555, freq_ref_o)
      alt_freq_src_i = 3'h1; cyc(1);
      `CHK("same source", 1'b1, same_source_error_o)
      freq_combine_i = 1'b0; alt_freq_src_i = 3'h0; cyc(3);
      `CHK("main only", 16'h0333, freq_ref_o)
   endtask
   task automatic s_comm_mem;
      main_freq_src_i = 3'h3;
      for (int m = 0; m < 2; m++) begin
         comm_mem_en_i = m[0];
         comm_freq_wr_i = 1'b1; cyc(1);
         comm_freq_wr_i = 1'b0; power_down_i = 1'b1; cyc(1);
         power_down_i = 1'b0; cyc(3);
         `CHK("comm kept", m ? 16'h0666 : 16'h0000, freq_ref_o)
      end
   endtask
   task automatic s_min_freq;
      main_freq_src_i = 3'h0; min_freq_i = 16'h0200; cyc(3);
      `CHK("below warn", 1'b1, below_min_freq_warning_o)
      min_detect_i = 1'b1; cyc(3);
      `CHK("clamp warn", 1'b0, below_min_freq_warning_o)
      `CHK("clamp", 16'h0200, freq_ref_o)
   endtask
   task automatic end_of_test;
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      err_count = 0; n_compared = 0; rst_b_i = 1'b0; press = 6'h00;
      term_func_i = '{default: 6'h02}; main_run_src_i = 3'h1;
      {alt_run_src_i, main_freq_src_i, alt_freq_src_i} = 9'h000;
      {dir_lock_i, key_run_i, key_rev_i, comm_run_i, comm_rev_i} = 5'h00;
      {logic_run_i, logic_rev_i, sched_run_i, sched_rev_i} = 4'h0;
      {freq_combine_i, ain2_current_i, comm_freq_wr_i} = 3'h0;
      {comm_mem_en_i, power_down_i, min_detect_i} = 3'h0;
      analog_mode_i = 8'h00; min_freq_i = 16'h0000; max_freq_i = 16'hf000;
      keypad_freq_i = 16'h0111; stage0_freq_i = 16'h0222;
      ain1_freq_i = 16'h0333; ain2_volt_freq_i = 16'h0444;
      ain2_curr_freq_i = 16'h0555; comm_freq_i = 16'h0666;
      sched_freq_i = 16'h0777;
      cyc(20);
      rst_b_i = 1'b1;
      s_two_wire(); s_three_wire(); s_latch(); s_alt_run();
      s_freq_src(); s_combine(); s_comm_mem(); s_min_freq();
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      $display("ERROR timeout expected end seen hang");
      end_of_test();
   end
endmodule
